/* File: logic/msd_pkg.sv */
package msd_pkg;

  // ==========================================================================
  // Command codes, packet lengths and layout.
  // ==========================================================================
  localparam logic [31:0] CMD_ENC_SET   = 32'h736E6573;
  localparam logic [31:0] CMD_MOTOR_SET = 32'h746E6573;
  localparam logic [31:0] CMD_EXT_SET   = 32'h74736573;
  localparam logic [31:0] CMD_FB_SET    = 32'h73626673;

  localparam logic [5:0] LEN_ENC_SET   = 6'h36;  // 54 bytes.
  localparam logic [5:0] LEN_MOTOR_SET = 6'h0E;  // 14 bytes.
  localparam logic [5:0] LEN_EXT_SET   = 6'h2E;  // 46 bytes.
  localparam logic [5:0] LEN_FB_SET    = 6'h12;  // 18 bytes.
  localparam logic [5:0] LEN_NONE      = 6'h00;
  localparam logic [5:0] IDX_MAX       = 6'h3F;

  localparam logic [5:0] CODE_BYTES  = 6'h04;
  localparam logic [5:0] CSUM_BYTES  = 6'h02;
  localparam logic [5:0] STAGE_END   = 6'h1C;  // Fields live in bytes 4..27.
  localparam int         STAGE_WORDS = 6;
  localparam logic [1:0] ANS_LAST    = 2'h3;   // Answer is 4 bytes.

  // ==========================================================================
  // Field positions and codes.
  // ==========================================================================
  localparam int ENC_DIFF_BIT   = 0;   // 0x1
  localparam int ENC_PP_BIT     = 2;   // 0x4
  localparam int ENC_INDEX_BIT  = 4;   // 0x10
  localparam int ENC_REV_BIT    = 6;   // 0x40
  localparam int ENC_REV_HI_BIT = 8;   // 0x100
  localparam int FB_REVERSE_BIT = 0;   // 0x1
  localparam int FB_KIND_LSB    = 6;   // Field 0xC0.

  localparam logic [7:0] MOTOR_NONE      = 8'h00;
  localparam logic [7:0] MOTOR_DC        = 8'h01;
  localparam logic [7:0] MOTOR_DUAL_DC   = 8'h02;
  localparam logic [7:0] MOTOR_STEPPER   = 8'h03;
  localparam logic [7:0] MOTOR_TEST      = 8'h04;
  localparam logic [7:0] MOTOR_BRUSHLESS = 8'h05;
  localparam logic [7:0] DRV_DISCRETE    = 8'h01;
  localparam logic [7:0] DRV_INTEGRATED  = 8'h02;
  localparam logic [7:0] DRV_EXTERNAL    = 8'h03;
  localparam logic [7:0] FB_ENCODER      = 8'h01;
  localparam logic [7:0] FB_BACK_EMF     = 8'h04;
  localparam logic [7:0] FB_NONE         = 8'h05;
  localparam logic [7:0] FB_ENC_GEARED   = 8'h06;
  localparam logic [1:0] KIND_AUTO       = 2'h0;
  localparam logic [1:0] KIND_SINGLE     = 2'h1;
  localparam logic [1:0] KIND_DIFF       = 2'h2;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0]  RST_MOTOR  = MOTOR_NONE;
  localparam logic [7:0]  RST_DRIVER = DRV_DISCRETE;
  localparam logic [7:0]  RST_FB     = FB_NONE;
  localparam logic [31:0] RST_WORD   = 32'h00000000;
  localparam logic [15:0] RST_SUM    = 16'h0000;

  typedef enum logic [1:0] {MSD_RX, MSD_CHECK, MSD_TX} msd_state_t;

endpackage : msd_pkg

/* File: logic/msd_sum_if.sv */
`timescale 1ns/1ps
interface msd_sum_if;
  logic        clear;
  logic        add;
  logic [7:0]  data;
  logic [15:0] sum;
  modport src (output clear, output add, output data, input sum);
  modport acc (input clear, input add, input data, output sum);
endinterface : msd_sum_if

/* File: logic/msd_sum.sv */
`timescale 1ns/1ps
module msd_sum
  import msd_pkg::*;
(
  input  wire logic clk,   // System clock.
  input  wire logic rst,   // Synchronous reset, active high.
  msd_sum_if.acc    port   // Clear, byte strobe and running sum.
);
  logic [15:0] sum;
  logic [15:0] next_sum;

  // ==========================================================================
  // Running 16-bit byte sum; clear has priority so a new frame starts clean.
  // ==========================================================================
  always_comb begin
    next_sum = sum;
    if (port.clear) begin
      next_sum = RST_SUM;
    end else if (port.add) begin
      next_sum = sum + {8'h00, port.data};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sum <= RST_SUM;
    end else begin
      sum <= next_sum;
    end
  end

  assign port.sum = sum;
endmodule : msd_sum

/* File: logic/msd_decoder.sv */
// Behaviour
// - Encoder-settings request has code 0x736E6573 and is exactly 54 bytes.
// - It carries frequency, two voltages, current floats, then 32-bit counts per rev.
// - Encoder flag word bits: differential, push-pull, index, rev sensor, rev active high.
// - Encoder-settings write is deprecated, stores to nonvolatile memory, manufacturer only.
// - Motor-and-driver request has code 0x746E6573, 14 bytes, two type bytes.
// - Motor codes: none, DC, dual DC, stepper, test, brushless.
// - Driver codes: discrete default, integrated IC, external.
// - Valid motor-and-driver request updates both motor and driver type.
// - Extended request has code 0x74736573, 46 bytes, one 16-bit parameter.
// - Extended request is accepted and answered but changes nothing.
// - Feedback request has code 0x73626673, 18 bytes, with its listed fields.
// - Feedback source codes: encoder, back-EMF, none, geared encoder.
// - Feedback flags: bit 0 reverses count, bits 7:6 select encoder kind.
`timescale 1ns/1ps
module msd_decoder
  import msd_pkg::*;
(
  input  wire logic        clk,                    // System clock, 200 MHz.
  input  wire logic        rst,                    // Synchronous reset, active high.
  input  wire logic [7:0]  rx_data,                // Request byte.
  input  wire logic        rx_valid,               // Request byte present.
  input  wire logic        rx_last,                // Byte ends the packet.
  output logic             rx_ready,               // Decoder takes a byte.
  output logic [7:0]       tx_data,                // Answer byte.
  output logic             tx_valid,               // Answer byte present.
  input  wire logic        tx_ready,               // Host takes answer byte.
  output logic             frame_error,            // Pulse: request rejected.
  output logic             nv_store_req,           // Pulse: store encoder data.
  output logic [31:0]      max_freq_khz,           // Float bits.
  output logic [31:0]      supply_min_v,           // Float bits.
  output logic [31:0]      supply_max_v,           // Float bits.
  output logic [31:0]      max_current_ma,         // Float bits.
  output logic [31:0]      encoder_counts_per_rev, // Encoder counts per rev.
  output logic [31:0]      encoder_flag_word,      // Raw encoder flag word.
  output logic             diff_output_flag,       // 1 differential, 0 single.
  output logic             push_pull_flag,         // 1 push-pull, 0 open drain.
  output logic             index_channel_flag,     // Index channel present.
  output logic             rev_sensor_flag,        // Revolution sensor present.
  output logic             rev_active_high,        // Sensor active high.
  output logic [7:0]       motor_type,             // Motor type code.
  output logic [7:0]       driver_type_a,          // Driver type code.
  output logic [15:0]      legacy_counts_per_rev,  // Obsolete 16-bit count.
  output logic [31:0]      wide_counts_per_rev,    // 32-bit count.
  output logic [31:0]      encoder_resolution,     // Count in effect.
  output logic [7:0]       feedback_source,        // Feedback type code.
  output logic [7:0]       feedback_flag_byte,     // Raw feedback flags.
  output logic             reverse_count_dir,      // Reverse encoder count.
  output logic [1:0]       encoder_kind_field      // 0 auto, 1 single, 2 diff.
);

  // ==========================================================================
  // Frame state.
  // ==========================================================================
  msd_state_t             state, next_state;
  logic [5:0]             idx, next_idx;
  logic [31:0]            code, next_code;
  logic [STAGE_WORDS-1:0][31:0] stage, next_stage;
  logic [15:0]            crc, next_crc;
  logic                   len_ok, next_len_ok;
  logic [1:0]             ans_cnt, next_ans_cnt;
  logic [5:0]             cmd_len;
  logic                   fire;
  logic [5:0]             sidx;

  msd_sum_if sum_bus ();

  msd_sum u_sum (
    .clk  (clk),
    .rst  (rst),
    .port (sum_bus)
  );

  // Unknown codes give zero length, which no packet matches.
  always_comb begin
    case (code)
      CMD_ENC_SET:   cmd_len = LEN_ENC_SET;
      CMD_MOTOR_SET: cmd_len = LEN_MOTOR_SET;
      CMD_EXT_SET:   cmd_len = LEN_EXT_SET;
      CMD_FB_SET:    cmd_len = LEN_FB_SET;
      default:       cmd_len = LEN_NONE;
    endcase
  end

  assign fire = rx_valid && rx_ready;
  assign sidx = idx - CODE_BYTES;

  // Payload bytes between code and checksum feed the running sum.
  assign sum_bus.clear = (state == MSD_CHECK);
  assign sum_bus.add   = fire && (idx >= CODE_BYTES) && (cmd_len != LEN_NONE)
                         && (idx < cmd_len - CSUM_BYTES);
  assign sum_bus.data  = rx_data;

  // ==========================================================================
  // Receive, check and answer sequence.
  // ==========================================================================
  always_comb begin
    next_state   = state;
    next_idx     = idx;
    next_code    = code;
    next_stage   = stage;
    next_crc     = crc;
    next_len_ok  = len_ok;
    next_ans_cnt = ans_cnt;
    case (state)
      MSD_RX: begin
        if (fire) begin
          if (idx != IDX_MAX) begin
            next_idx = idx + 6'h01;
          end
          // Fields are little-endian; the code arrives as its ASCII letters.
          if (idx < CODE_BYTES) begin
            next_code[8*idx[1:0] +: 8] = rx_data;
          end else if (idx < STAGE_END) begin
            next_stage[sidx[4:2]][8*sidx[1:0] +: 8] = rx_data;
          end
          if (cmd_len != LEN_NONE && idx == cmd_len - CSUM_BYTES) begin
            next_crc[7:0] = rx_data;
          end
          if (cmd_len != LEN_NONE && idx == cmd_len - 6'h01) begin
            next_crc[15:8] = rx_data;
          end
          if (rx_last) begin
            // A frame longer than the index can count never matches.
            next_len_ok = (idx != IDX_MAX) && (idx + 6'h01 == cmd_len);
            next_state  = MSD_CHECK;
          end
        end
      end
      MSD_CHECK: begin
        next_idx     = 6'h00;
        next_ans_cnt = 2'h0;
        if (len_ok && crc == sum_bus.sum) begin
          next_state = MSD_TX;
        end else begin
          next_state = MSD_RX;
        end
      end
      MSD_TX: begin
        if (tx_ready) begin
          next_ans_cnt = ans_cnt + 2'h1;
          if (ans_cnt == ANS_LAST) begin
            next_state = MSD_RX;
          end
        end
      end
      default: begin
        next_state = MSD_RX;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= MSD_RX;
      idx     <= 6'h00;
      code    <= RST_WORD;
      stage   <= '0;
      crc     <= RST_SUM;
      len_ok  <= 1'b0;
      ans_cnt <= 2'h0;
    end else begin
      state   <= next_state;
      idx     <= next_idx;
      code    <= next_code;
      stage   <= next_stage;
      crc     <= next_crc;
      len_ok  <= next_len_ok;
      ans_cnt <= next_ans_cnt;
    end
  end

  // ==========================================================================
  // Settings and port registers; settings change only on an accepted packet.
  // ==========================================================================
  logic        accept;
  logic        next_rx_ready, next_tx_valid, next_frame_error, next_nv_store;
  logic [7:0]  next_tx_data;
  logic [31:0] next_freq, next_vmin, next_vmax, next_imax, next_ppr, next_eflags;
  logic [7:0]  next_motor, next_driver, next_fb_src, next_fb_flags;
  logic [15:0] next_legacy;
  logic [31:0] next_wide, next_res;

  assign accept = (state == MSD_CHECK) && (next_state == MSD_TX);

  always_comb begin
    next_rx_ready    = (next_state == MSD_RX);
    next_tx_valid    = (next_state == MSD_TX);
    next_tx_data     = next_code[8*next_ans_cnt +: 8];
    next_frame_error = (state == MSD_CHECK) && (next_state == MSD_RX);
    next_nv_store    = 1'b0;
    next_freq        = max_freq_khz;
    next_vmin        = supply_min_v;
    next_vmax        = supply_max_v;
    next_imax        = max_current_ma;
    next_ppr         = encoder_counts_per_rev;
    next_eflags      = encoder_flag_word;
    next_motor       = motor_type;
    next_driver      = driver_type_a;
    next_legacy      = legacy_counts_per_rev;
    next_wide        = wide_counts_per_rev;
    next_res         = encoder_resolution;
    next_fb_src      = feedback_source;
    next_fb_flags    = feedback_flag_byte;
    if (accept) begin
      case (code)
        CMD_ENC_SET: begin
          next_freq     = stage[0];
          next_vmin     = stage[1];
          next_vmax     = stage[2];
          next_imax     = stage[3];
          next_ppr      = stage[4];
          next_eflags   = stage[5];
          // Nonvolatile storage lives outside; this pulse asks for it.
          next_nv_store = 1'b1;
        end
        CMD_MOTOR_SET: begin
          // Codes are passed through unchecked; policing them is the host's job.
          next_motor  = stage[0][7:0];
          next_driver = stage[0][15:8];
        end
        CMD_FB_SET: begin
          next_legacy   = stage[0][15:0];
          next_fb_src   = stage[0][23:16];
          next_fb_flags = stage[0][31:24];
          next_wide     = stage[1];
          next_res      = (stage[0][15:0] != 16'h0000) ?
                          {16'h0000, stage[0][15:0]} : stage[1];
        end
        default: begin
          // The extended request only earns its answer.
          next_res = encoder_resolution;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ready               <= 1'b0;
      tx_valid               <= 1'b0;
      tx_data                <= 8'h00;
      frame_error            <= 1'b0;
      nv_store_req           <= 1'b0;
      max_freq_khz           <= RST_WORD;
      supply_min_v           <= RST_WORD;
      supply_max_v           <= RST_WORD;
      max_current_ma         <= RST_WORD;
      encoder_counts_per_rev <= RST_WORD;
      encoder_flag_word      <= RST_WORD;
      motor_type             <= RST_MOTOR;
      driver_type_a          <= RST_DRIVER;
      legacy_counts_per_rev  <= RST_SUM;
      wide_counts_per_rev    <= RST_WORD;
      encoder_resolution     <= RST_WORD;
      feedback_source        <= RST_FB;
      feedback_flag_byte     <= 8'h00;
    end else begin
      rx_ready               <= next_rx_ready;
      tx_valid               <= next_tx_valid;
      tx_data                <= next_tx_data;
      frame_error            <= next_frame_error;
      nv_store_req           <= next_nv_store;
      max_freq_khz           <= next_freq;
      supply_min_v           <= next_vmin;
      supply_max_v           <= next_vmax;
      max_current_ma         <= next_imax;
      encoder_counts_per_rev <= next_ppr;
      encoder_flag_word      <= next_eflags;
      motor_type             <= next_motor;
      driver_type_a          <= next_driver;
      legacy_counts_per_rev  <= next_legacy;
      wide_counts_per_rev    <= next_wide;
      encoder_resolution     <= next_res;
      feedback_source        <= next_fb_src;
      feedback_flag_byte     <= next_fb_flags;
    end
  end

  // Decoded flags are plain bits of their registered words.
  always_ff @(posedge clk) begin
    if (rst) begin
      diff_output_flag   <= 1'b0;
      push_pull_flag     <= 1'b0;
      index_channel_flag <= 1'b0;
      rev_sensor_flag    <= 1'b0;
      rev_active_high    <= 1'b0;
      reverse_count_dir  <= 1'b0;
      encoder_kind_field <= KIND_AUTO;
    end else begin
      diff_output_flag   <= next_eflags[ENC_DIFF_BIT];
      push_pull_flag     <= next_eflags[ENC_PP_BIT];
      index_channel_flag <= next_eflags[ENC_INDEX_BIT];
      rev_sensor_flag    <= next_eflags[ENC_REV_BIT];
      rev_active_high    <= next_eflags[ENC_REV_HI_BIT];
      reverse_count_dir  <= next_fb_flags[FB_REVERSE_BIT];
      encoder_kind_field <= next_fb_flags[FB_KIND_LSB +: 2];
    end
  end

endmodule : msd_decoder

/* File: test/msd_decoder_props.sv */
`timescale 1ns/1ps
module msd_props (
  input wire logic        clk,                    // Clock.
  input wire logic        rst,                    // Reset.
  input wire logic        rx_valid,               // Byte offered.
  input wire logic        rx_last,                // Last byte.
  input wire logic        rx_ready,               // Byte taken.
  input wire logic [7:0]  tx_data,                // Answer byte.
  input wire logic        tx_valid,               // Answer valid.
  input wire logic        tx_ready,               // Answer taken.
  input wire logic        frame_error,            // Reject pulse.
  input wire logic        nv_store_req,           // Store pulse.
  input wire logic [31:0] encoder_flag_word,      // Flag word.
  input wire logic        diff_output_flag,       // Flag bit 0.
  input wire logic        push_pull_flag,         // Flag bit 2.
  input wire logic        index_channel_flag,     // Flag bit 4.
  input wire logic        rev_sensor_flag,        // Flag bit 6.
  input wire logic        rev_active_high,        // Flag bit 8.
  input wire logic [7:0]  motor_type,             // Motor code.
  input wire logic [7:0]  driver_type_a,          // Driver code.
  input wire logic [15:0] legacy_counts_per_rev,  // Old count.
  input wire logic [31:0] wide_counts_per_rev,    // Wide count.
  input wire logic [31:0] encoder_resolution,     // Count used.
  input wire logic [7:0]  feedback_source,        // Source code.
  input wire logic [7:0]  feedback_flag_byte,     // Feedback flags.
  input wire logic        reverse_count_dir,      // Reverse bit.
  input wire logic [1:0]  encoder_kind_field      // Kind field.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Framing, answer and settings checks.
  // ==========================================================================
  outcome_time_a: assert property (rx_valid && rx_ready && rx_last |=>
    !rx_ready ##1 (tx_valid || frame_error))
    else $error("no outcome after last byte");
  reject_silent_a: assert property (frame_error |-> !tx_valid && !nv_store_req)
    else $error("answer on rejected packet");
  reject_keeps_a: assert property (frame_error |->
    $stable(motor_type) && $stable(driver_type_a) && $stable(feedback_source))
    else $error("setting changed on reject");
  resolution_pick_a: assert property (encoder_resolution ==
    (legacy_counts_per_rev != 16'h0000 ? {16'h0000, legacy_counts_per_rev} : wide_counts_per_rev))
    else $error("wrong resolution source");
  enc_bits_a: assert property ({rev_active_high, rev_sensor_flag, index_channel_flag,
    push_pull_flag, diff_output_flag} == {encoder_flag_word[8], encoder_flag_word[6],
    encoder_flag_word[4], encoder_flag_word[2], encoder_flag_word[0]})
    else $error("encoder flag decode wrong");
  fb_bits_a: assert property (reverse_count_dir == feedback_flag_byte[0] &&
    encoder_kind_field == feedback_flag_byte[7:6])
    else $error("feedback flag decode wrong");
  store_pulse_a: assert property (nv_store_req |-> tx_valid ##1 !nv_store_req)
    else $error("store pulse malformed");
  answer_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("answer byte not held");
  busy_answer_a: assert property (tx_valid |-> !rx_ready)
    else $error("taking bytes while answering");
  type_update_a: assert property (!$stable(motor_type) || !$stable(driver_type_a) |->
    $rose(tx_valid))
    else $error("type changed without accept");
  cover property (frame_error);
  cover property (nv_store_req);
  cover property (tx_valid && !tx_ready);
endmodule : msd_props

bind msd_decoder msd_props u_props (
  .clk, .rst, .rx_valid, .rx_last, .rx_ready, .tx_data, .tx_valid, .tx_ready, .frame_error,
  .nv_store_req, .encoder_flag_word, .diff_output_flag, .push_pull_flag, .index_channel_flag,
  .rev_sensor_flag, .rev_active_high, .motor_type, .driver_type_a, .legacy_counts_per_rev,
  .wide_counts_per_rev, .encoder_resolution, .feedback_source, .feedback_flag_byte,
  .reverse_count_dir, .encoder_kind_field
);

/* File: test/msd_host.sv */
`timescale 1ns/1ps
module msd_host (
  input  wire logic       clk,       // System clock.
  output logic [7:0]      rx_data,   // Request byte.
  output logic            rx_valid,  // Request byte present.
  output logic            rx_last,   // Final byte.
  input  wire logic       rx_ready,  // Decoder takes byte.
  input  wire logic [7:0] tx_data,   // Answer byte.
  input  wire logic       tx_valid,  // Answer byte present.
  output logic            tx_ready   // Host takes answer.
);
  logic [7:0] pkt [64];
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
  end
  // ==========================================================================
  // Packet transfer; skew spoils the checksum on purpose.
  // ==========================================================================
  task automatic send(input int len, input logic [15:0] skew);
    logic [15:0] sum;
    int          n;
    sum = skew;
    for (int i = 4; i < len - 2; i++) sum += 16'(pkt[i]);
    pkt[len-2] = sum[7:0];
    pkt[len-1] = sum[15:8];
    for (int i = 0; i < len; i++) begin
      @(negedge clk);
      rx_valid <= 1'b1;
      rx_data  <= pkt[i];
      rx_last  <= (i == len - 1);
      n = 0;
      do begin @(posedge clk); n++; end while (!rx_ready && n < 100);
      if (!rx_ready) test_msd_decoder.hang();
    end
    @(negedge clk);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    // A released line must not look like a held byte.
    rx_data  <= ~rx_data;
  endtask : send
  task automatic get_ans(input int stall, output logic [31:0] code);
    int n;
    for (int b = 0; b < 4; b++) begin
      @(negedge clk);
      if (stall > 0) begin
        tx_ready <= 1'b0;
        repeat (stall) @(negedge clk);
      end
      tx_ready <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (!tx_valid && n < 100);
      if (!tx_valid) test_msd_decoder.hang();
      code[8*b +: 8] = tx_data;
    end
    @(negedge clk);
    tx_ready <= 1'b0;
  endtask : get_ans
endmodule : msd_host

/* File: test/test_msd_decoder.sv */
`timescale 1ns/1ps
module test_msd_decoder
  import msd_pkg::*;
;
  logic        clk, rst, rx_valid, rx_last, rx_ready, tx_valid, tx_ready, frame_error;
  logic        nv_store_req, diff_output_flag, push_pull_flag, index_channel_flag;
  logic        rev_sensor_flag, rev_active_high, reverse_count_dir;
  logic [1:0]  encoder_kind_field;
  logic [7:0]  rx_data, tx_data, motor_type, driver_type_a, feedback_source, feedback_flag_byte;
  logic [15:0] legacy_counts_per_rev;
  logic [31:0] max_freq_khz, supply_min_v, supply_max_v, max_current_ma, encoder_counts_per_rev;
  logic [31:0] encoder_flag_word, wide_counts_per_rev, encoder_resolution;
  int          n_mismatch, total_checks;
  msd_decoder uut (.clk, .rst, .rx_data, .rx_valid, .rx_last, .rx_ready, .tx_data, .tx_valid,
    .tx_ready, .frame_error, .nv_store_req, .max_freq_khz, .supply_min_v, .supply_max_v,
    .max_current_ma, .encoder_counts_per_rev, .encoder_flag_word, .diff_output_flag,
    .push_pull_flag, .index_channel_flag, .rev_sensor_flag, .rev_active_high, .motor_type,
    .driver_type_a, .legacy_counts_per_rev, .wide_counts_per_rev, .encoder_resolution,
    .feedback_source, .feedback_flag_byte, .reverse_count_dir, .encoder_kind_field);
  msd_host host (.clk, .rx_data, .rx_valid, .rx_last, .rx_ready, .tx_data, .tx_valid, .tx_ready);
  always #2.5 clk = ~clk;
  // ==========================================================================
  // Shared helpers.
  // ==========================================================================
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic hang;
    n_mismatch++;
    $display("wrong value wait expected done seen stuck");
    final_report();
  endtask : hang
  task automatic put(int at, logic [31:0] v);
    for (int i = 0; i < 4; i++) host.pkt[at+i] = v[8*i +: 8];
  endtask : put
  task automatic build(logic [31:0] code);
    // Nonzero reserved bytes make the checksum cover them.
    for (int i = 0; i < 64; i++) host.pkt[i] = 8'h5A;
    put(0, code);
  endtask : build
  task automatic result(logic ok, logic nv, int stall);
    logic [31:0] got;
    logic        seen;
    int          n;
    seen = 1'b0;
    n = 0;
    do begin @(negedge clk); n++; seen |= nv_store_req;
    end while (!tx_valid && !frame_error && n < 20);
    if (n >= 20) hang();
    chk("accepted", ok, tx_valid);
    chk("rejected", !ok, frame_error);
    chk("store", nv, seen);
    if (tx_valid) begin
      host.get_ans(stall, got);
      chk("echo", {host.pkt[3], host.pkt[2], host.pkt[1], host.pkt[0]}, got);
    end
  endtask : result
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic motor_cases;
    for (int m = 1; m <= 5; m++) begin
      build(CMD_MOTOR_SET);
      put(4, {16'h5A5A, 8'(m % 3 + 1), 8'(m)});
      host.send(LEN_MOTOR_SET, 16'h0000);
      result(1'b1, 1'b0, m % 2);
      chk("motor", m, motor_type);
      chk("driver", m % 3 + 1, driver_type_a);
    end
  endtask : motor_cases
  task automatic enc_case(logic [31:0] fl);
    build(CMD_ENC_SET);
    put(4, 32'h447A0000);
    put(8, 32'h40A00000);
    put(12, 32'h41C00000);
    put(16, 32'h43FA0000);
    put(20, 32'h00010000 + fl);
    put(24, fl);
    host.send(LEN_ENC_SET, 16'h0000);
    result(1'b1, 1'b1, 0);
    chk("freq", 32'h447A0000, max_freq_khz);
    chk("vmin", 32'h40A00000, supply_min_v);
    chk("vmax", 32'h41C00000, supply_max_v);
    chk("current", 32'h43FA0000, max_current_ma);
    chk("ppr", 32'h00010000 + fl, encoder_counts_per_rev);
    chk("flags", {fl[8], fl[6], fl[4], fl[2], fl[0]}, {rev_active_high, rev_sensor_flag,
      index_channel_flag, push_pull_flag, diff_output_flag});
  endtask : enc_case
  task automatic ext_case;
    build(CMD_EXT_SET);
    put(4, 32'h5A5ABEEF);
    host.send(LEN_EXT_SET, 16'h0000);
    result(1'b1, 1'b0, 2);
    chk("motor kept", MOTOR_BRUSHLESS, motor_type);
    chk("flags kept", 32'h000000AA, encoder_flag_word);
    chk("source kept", FB_NONE, feedback_source);
  endtask : ext_case
  task automatic fb_cases;
    logic [7:0] src [4] = '{FB_ENCODER, FB_BACK_EMF, FB_NONE, FB_ENC_GEARED};
    logic [7:0] fl [4]  = '{8'h00, 8'h41, 8'h80, 8'h01};
    for (int k = 0; k < 4; k++) begin
      build(CMD_FB_SET);
      put(4, {fl[k], src[k], k[0] ? 16'h1234 : 16'h0000});
      put(8, 32'h00012345 + k);
      host.send(LEN_FB_SET, 16'h0000);
      result(1'b1, 1'b0, 0);
      chk("source", src[k], feedback_source);
      chk("reverse", fl[k][0], reverse_count_dir);
      chk("kind", fl[k][7:6], encoder_kind_field);
      chk("resolution", k[0] ? 32'h1234 : 32'h12345 + k, encoder_resolution);
    end
  endtask : fb_cases
  task automatic bad_cases;
    build(CMD_MOTOR_SET);
    put(4, {16'h5A5A, DRV_INTEGRATED, MOTOR_STEPPER});
    host.send(LEN_MOTOR_SET, 16'h0001);
    result(1'b0, 1'b0, 0);
    host.send(LEN_MOTOR_SET - 1, 16'h0000);
    result(1'b0, 1'b0, 0);
    chk("motor kept", MOTOR_BRUSHLESS, motor_type);
    host.send(LEN_MOTOR_SET, 16'h0000);
    result(1'b1, 1'b0, 0);
    chk("motor", MOTOR_STEPPER, motor_type);
    chk("driver", DRV_INTEGRATED, driver_type_a);
  endtask : bad_cases
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    chk("reset motor", MOTOR_NONE, motor_type);
    chk("reset driver", DRV_DISCRETE, driver_type_a);
    chk("reset ready", 1'b0, rx_ready);
    rst = 1'b0;
    motor_cases();
    enc_case(32'h00000155);
    enc_case(32'h000000AA);
    ext_case();
    fb_cases();
    bad_cases();
    final_report();
  end
endmodule : test_msd_decoder
